// [design/sgps_cfg.svh]
// Constants of the sensor and general pin status block: offsets, fields, resets.
// Assumes it is included by bare name from the package and design files.
`ifndef SGPS_CFG_SVH
`define SGPS_CFG_SVH

// ==========================================================================
// Sizes
`define SGPS_NPIN        8
`define SGPS_NGP         6
`define SGPS_AW          12
`define SGPS_IDX_W       7
`define SGPS_LINE_W      16
`define SGPS_NEV         3

// ==========================================================================
// APB word offsets (byte addresses)
`define SGPS_OFF_INDEX   12'h000
`define SGPS_OFF_DATA    12'h004
`define SGPS_OFF_ISTAT   12'h008
`define SGPS_OFF_ICLR    12'h00C
`define SGPS_OFF_IEN     12'h010

// ==========================================================================
// Indexed configuration register numbers
`define SGPS_IDX_STATUS  7'h02
`define SGPS_IDX_CMD     7'h07
`define SGPS_IDX_STOP    7'h50
`define SGPS_IDX_LINES   7'h51
`define SGPS_IDX_DIR     7'h58
`define SGPS_IDX_POL     7'h59
`define SGPS_IDX_SENS    7'h5A
`define SGPS_IDX_OUTV    7'h5B

// ==========================================================================
// Field positions
`define SGPS_GP_LSB      2
`define SGPS_STOP_PS1    0
`define SGPS_STOP_PS2    1
`define SGPS_EV_PS1      0
`define SGPS_EV_PS2      1
`define SGPS_EV_EDGE     2

// ==========================================================================
// Reset values
`define SGPS_RST_DIR     8'hE0
`define SGPS_RST_POL     8'h00
`define SGPS_RST_SENS    8'h1C
`define SGPS_RST_OUTV    8'h60
`define SGPS_RST_STOP    2'h0
`define SGPS_RST_LINES   16'h0000

`endif

// [design/sgps_pin.sv]
// One sensing input: polarity, level or edge mode, sticky edge flag.
// Assumes a synchronised pin level and a per-bit clear from a status read.
`timescale 1ns/1ps

module sgps_pin (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic pin,
    input  wire logic pol,
    input  wire logic sens,
    input  wire logic clr,
    output logic      state,
    output logic      rise
);
    import sgps_pkg::*;

    sgps_pin_s s;
    sgps_pin_s next_s;
    logic      cond;

    // ======================================================================
    // Polarity, false-to-true detect, sticky flag where a new edge beats clear
    always_comb
    begin
        cond        = pol ? pin : ~pin;
        rise        = cond & ~s.prev;
        next_s      = s;
        next_s.prev = cond;
        next_s.flag = rise | (s.flag & ~clr);
        state       = sens ? s.flag : cond;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            s <= '0;
        else
            s <= next_s;
    end

endmodule : sgps_pin

// [design/sgps_pkg.sv]
// Types shared by the sensor and general pin status block.
// Assumes sgps_cfg.svh is on the include path.
`include "sgps_cfg.svh"

package sgps_pkg;

    // ======================================================================
    // Motion command held by the block
    typedef enum logic [2:0] {
        SGPS_IDLE    = 3'b000,
        SGPS_FWD     = 3'b001,
        SGPS_REV     = 3'b010,
        SGPS_SCAN    = 3'b011,
        SGPS_SOFTRST = 3'b100
    } sgps_motion_e;

    // ======================================================================
    // State records
    typedef struct packed {
        logic [`SGPS_NPIN-1:0] s1;
        logic [`SGPS_NPIN-1:0] s2;
    } sgps_sync_s;

    typedef struct packed {
        logic prev;
        logic flag;
    } sgps_pin_s;

    typedef struct packed {
        logic [`SGPS_IDX_W-1:0]  index;
        logic [7:0]              dir;
        logic [7:0]              pol;
        logic [7:0]              sens;
        logic [7:0]              outv;
        sgps_motion_e            cmd;
        logic [1:0]              stopcfg;
        logic [`SGPS_LINE_W-1:0] lines;
        logic [`SGPS_LINE_W-1:0] ps2_cnt;
        logic                    ps2_run;
        logic                    ps2_late;
        logic [`SGPS_NEV-1:0]    ev_stat;
        logic [`SGPS_NEV-1:0]    ev_en;
        logic                    irq;
        logic [31:0]             prdata;
        logic                    pready;
        logic                    pslverr;
    } sgps_top_s;

endpackage : sgps_pkg

// [design/sgps_sync.sv]
// Two-stage synchroniser for all eight sensing pins.
// Assumes the pins are asynchronous to ref_clk.
`timescale 1ns/1ps
`include "sgps_cfg.svh"

module sgps_sync (
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  wire logic [`SGPS_NPIN-1:0] raw,
    output logic      [`SGPS_NPIN-1:0] synced
);
    import sgps_pkg::*;

    sgps_sync_s s;
    sgps_sync_s next_s;

    // ======================================================================
    // First stage feeds only the second stage
    always_comb
    begin
        next_s    = s;
        next_s.s1 = raw;
        next_s.s2 = s.s1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            s <= '1; // Idle level of pulled-up pins, so no false edge follows reset
        else
            s <= next_s;
    end

    assign synced = s.s2;

endmodule : sgps_sync

// [design/sgps_top.sv]
// Sensor and general pin status block with APB access to an indexed register set.
// Assumes APB master on ref_clk, pins asynchronous, line_tick and suspend on ref_clk.
//
// How it works
// [RL1] Two input-only sheet sensors and six general pins all show their state in status.
// [RL2] A direction bit of 0 makes a general pin an input and 1 makes it an output.
// [RL3] Polarity 1 makes a high pin read true, polarity 0 makes a low pin read true.
// [RL4] In level mode a status bit follows the polarity-adjusted pin continuously.
// [RL5] In edge mode a status bit is true if a false-to-true change came since the last read.
// [RL6] Reading the status register clears all edge-mode flags to false; here only the flags that the read returned as true are cleared.
// [RL7] When enabled, sheet sensor one going true stops scan, fast forward or fast reverse.
// [RL8] When enabled, sheet sensor two stops scan or fast forward and sets its bit N lines later.
// [RL9] Sheet sensor two never stops fast reverse motion.
// [RL10] An output general pin drives high for a written 1 and low for a written 0.
// [RL11] Pin settings return to defaults on reset and suspend, not on soft reset.
// [RL12] By default general pins one to three are edge inputs reporting falling edges on bits 2-4.
// [RL13] By default general pins four and five drive high and pin six drives low.
// [RL14] Software writes a register index once, then any number of data accesses use it.
// [RL15] Software does not write registers 0, 1 or 2; they are read-only here.
// [RL16] Pin registers 58-5B take writes while idle; most others only in soft reset.
// [RL17] Every input pin passes a two-stage synchroniser before any processing.
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "sgps_cfg.svh"

module sgps_top (
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [`SGPS_AW-1:0]   paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  sheet_sense1,
    input  wire logic                  sheet_sense2,
    input  wire logic [`SGPS_NGP-1:0]  gp_in,
    output logic      [`SGPS_NGP-1:0]  gp_out,
    output logic      [`SGPS_NGP-1:0]  gp_oe,
    input  wire logic                  line_tick,
    input  wire logic                  suspend,
    output sgps_pkg::sgps_motion_e     motion,
    output logic                       irq
);
    import sgps_pkg::*;

    // ======================================================================
    // Write permission by index and current command
    function automatic logic sgps_wr_ok(input logic [`SGPS_IDX_W-1:0] idx,
                                        input sgps_motion_e cmd);
        logic ok;
        ok = 1'b0;
        if (idx <= `SGPS_IDX_STATUS)
            ok = 1'b0;
        else if (idx == `SGPS_IDX_CMD)
            ok = 1'b1;
        else if (idx >= `SGPS_IDX_DIR && idx <= `SGPS_IDX_OUTV)
            ok = (cmd == SGPS_IDLE) || (cmd == SGPS_SOFTRST);
        else
            ok = (cmd == SGPS_SOFTRST);
        return ok;
    endfunction : sgps_wr_ok

    // ======================================================================
    // Declarations
    sgps_top_s             s;
    sgps_top_s             next_s;
    logic [`SGPS_NPIN-1:0] pin_s;
    logic [`SGPS_NPIN-1:0] cell_st;
    logic [`SGPS_NPIN-1:0] cell_rise;
    logic [`SGPS_NPIN-1:0] clr_mask;
    logic [7:0]            stat_vec;
    logic                  access;
    logic                  setup;
    logic                  wr_data;
    logic                  wr_ok;
    logic                  rd_status;
    logic                  ps1_stop;
    logic                  ps2_done;
    logic                  moving_fwd;
    logic [`SGPS_NEV-1:0]  ev_set;
    logic [31:0]           rd_val;
    logic                  map_hit;

    // ======================================================================
    // Pin synchronisers and per-pin processing
    sgps_sync u_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .raw     ({gp_in, sheet_sense2, sheet_sense1}), // [RL17]
        .synced  (pin_s)
    );

    genvar gi;
    generate
        for (gi = 0; gi < `SGPS_NPIN; gi++)
        begin : g_pin
            sgps_pin u_pin (
                .ref_clk (ref_clk),
                .rst_n   (rst_n),
                .pin     (pin_s[gi]),
                .pol     (s.pol[gi]),
                .sens    (s.sens[gi]),
                .clr     (clr_mask[gi]),
                .state   (cell_st[gi]),
                .rise    (cell_rise[gi])
            );
        end
    endgenerate

    // ======================================================================
    // Bus phase decode; pready is a flop, so accesses finish with no wait
    always_comb
    begin
        setup     = psel & ~penable;
        access    = psel & penable & s.pready;
        wr_data   = access & pwrite & (paddr == `SGPS_OFF_DATA);
        wr_ok     = sgps_wr_ok(s.index, s.cmd);
        rd_status = access & ~pwrite & (paddr == `SGPS_OFF_DATA)
                    & (s.index == `SGPS_IDX_STATUS);
        // Only the bits actually returned are cleared, so a late edge survives
        clr_mask  = rd_status ? s.prdata[7:0] : 8'h00; // [RL6]
    end

    // ======================================================================
    // Status word: sensor two shows its delayed flag when its stop is armed
    always_comb
    begin
        stat_vec    = cell_st; // [RL1]
        stat_vec[1] = s.stopcfg[`SGPS_STOP_PS2] ? s.ps2_late : cell_st[1]; // [RL8]
        stat_vec[`SGPS_GP_LSB-1:0] = stat_vec[`SGPS_GP_LSB-1:0];
    end

    // ======================================================================
    // Motion stop conditions
    always_comb
    begin
        moving_fwd = (s.cmd == SGPS_SCAN) || (s.cmd == SGPS_FWD);
        ps1_stop   = cell_rise[0] & s.stopcfg[`SGPS_STOP_PS1]
                     & (moving_fwd || (s.cmd == SGPS_REV)); // [RL7]
        ps2_done   = s.ps2_run & (s.ps2_cnt == '0);
        ev_set     = '0;
        ev_set[`SGPS_EV_PS1]  = ps1_stop;
        ev_set[`SGPS_EV_PS2]  = ps2_done;
        ev_set[`SGPS_EV_EDGE] = |(cell_rise & s.sens);
    end

    // ======================================================================
    // Read mux for the setup phase; unmapped offsets read zero with an error
    always_comb
    begin
        rd_val  = 32'h0000_0000;
        map_hit = 1'b1;
        case (paddr)
            `SGPS_OFF_INDEX: rd_val[`SGPS_IDX_W-1:0] = s.index;
            `SGPS_OFF_ISTAT: rd_val[`SGPS_NEV-1:0] = s.ev_stat;
            `SGPS_OFF_ICLR:  rd_val = 32'h0000_0000;
            `SGPS_OFF_IEN:   rd_val[`SGPS_NEV-1:0] = s.ev_en;
            `SGPS_OFF_DATA:
            begin
                case (s.index)
                    `SGPS_IDX_STATUS: rd_val[7:0] = stat_vec; // [RL1]
                    `SGPS_IDX_CMD:    rd_val[2:0] = s.cmd;
                    `SGPS_IDX_STOP:   rd_val[1:0] = s.stopcfg;
                    `SGPS_IDX_LINES:  rd_val[`SGPS_LINE_W-1:0] = s.lines;
                    `SGPS_IDX_DIR:    rd_val[7:0] = s.dir;
                    `SGPS_IDX_POL:    rd_val[7:0] = s.pol;
                    `SGPS_IDX_SENS:   rd_val[7:0] = s.sens;
                    `SGPS_IDX_OUTV:   rd_val[7:0] = s.outv;
                    default:          rd_val = 32'h0000_0000;
                endcase
            end
            default: map_hit = 1'b0;
        endcase
    end

    // ======================================================================
    // Next state
    always_comb
    begin
        next_s        = s;
        next_s.pready = 1'b1;

        // Answer is prepared in setup so it is ready in the access phase
        if (setup)
        begin
            next_s.prdata  = rd_val;
            next_s.pslverr = ~map_hit;
        end

        // Index write selects the register for all following data accesses
        if (access & pwrite & (paddr == `SGPS_OFF_INDEX))
            next_s.index = pwdata[`SGPS_IDX_W-1:0]; // [RL14]

        // Sensor two delay counter counts whole lines after its pin goes true
        if (cell_rise[1] & s.stopcfg[`SGPS_STOP_PS2])
        begin
            next_s.ps2_run = 1'b1;
            next_s.ps2_cnt = s.lines;
        end
        else if (ps2_done)
            next_s.ps2_run = 1'b0;
        else if (s.ps2_run & line_tick)
            next_s.ps2_cnt = s.ps2_cnt - 1'b1;

        if (ps2_done)
            next_s.ps2_late = 1'b1; // [RL8]
        else if (clr_mask[1])
            next_s.ps2_late = 1'b0;

        // Sensor stops act on the running command; reverse is immune to sensor two
        if (ps1_stop)
            next_s.cmd = SGPS_IDLE; // [RL7]
        else if (ps2_done & moving_fwd)
            next_s.cmd = SGPS_IDLE; // [RL8] [RL9]

        // Data writes, gated by the current command
        if (wr_data & wr_ok) // [RL16] [RL15]
        begin
            case (s.index)
                `SGPS_IDX_CMD:
                begin
                    case (pwdata[2:0])
                        3'h1:    next_s.cmd = SGPS_FWD;
                        3'h2:    next_s.cmd = SGPS_REV;
                        3'h3:    next_s.cmd = SGPS_SCAN;
                        3'h4:    next_s.cmd = SGPS_SOFTRST;
                        default: next_s.cmd = SGPS_IDLE;
                    endcase
                end
                `SGPS_IDX_STOP:  next_s.stopcfg = pwdata[1:0];
                `SGPS_IDX_LINES: next_s.lines = pwdata[`SGPS_LINE_W-1:0];
                // Sheet sensors are inputs only, so their direction bits stay zero
                `SGPS_IDX_DIR:   next_s.dir = {pwdata[7:`SGPS_GP_LSB], 2'h0}; // [RL2]
                `SGPS_IDX_POL:   next_s.pol = pwdata[7:0]; // [RL3]
                `SGPS_IDX_SENS:  next_s.sens = pwdata[7:0]; // [RL4] [RL5]
                `SGPS_IDX_OUTV:  next_s.outv = {pwdata[7:`SGPS_GP_LSB], 2'h0}; // [RL10]
                default:         next_s.index = s.index;
            endcase
        end

        // Suspend holds pin settings at their defaults; soft reset does not touch them
        if (suspend)
        begin
            next_s.dir  = `SGPS_RST_DIR;  // [RL11]
            next_s.pol  = `SGPS_RST_POL;
            next_s.sens = `SGPS_RST_SENS;
            next_s.outv = `SGPS_RST_OUTV;
        end

        // Interrupt events: set wins over a clear in the same cycle
        next_s.ev_stat = s.ev_stat;
        if (access & pwrite & (paddr == `SGPS_OFF_ICLR))
            next_s.ev_stat = s.ev_stat & ~pwdata[`SGPS_NEV-1:0];
        next_s.ev_stat = next_s.ev_stat | ev_set;
        if (access & pwrite & (paddr == `SGPS_OFF_IEN))
            next_s.ev_en = pwdata[`SGPS_NEV-1:0];
        next_s.irq = |(next_s.ev_stat & next_s.ev_en);
    end

    // ======================================================================
    // State register
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            s         <= '0;
            s.dir     <= `SGPS_RST_DIR;  // [RL11] [RL12] [RL13]
            s.pol     <= `SGPS_RST_POL;
            s.sens    <= `SGPS_RST_SENS;
            s.outv    <= `SGPS_RST_OUTV;
            s.stopcfg <= `SGPS_RST_STOP;
            s.lines   <= `SGPS_RST_LINES;
            s.cmd     <= SGPS_IDLE;
        end
        else
            s <= next_s;
    end

    // ======================================================================
    // Outputs, all straight from flops
    assign prdata  = s.prdata;
    assign pready  = s.pready;
    assign pslverr = s.pslverr;
    assign gp_out  = s.outv[7:`SGPS_GP_LSB]; // [RL10]
    assign gp_oe   = s.dir[7:`SGPS_GP_LSB];  // [RL2]
    assign motion  = s.cmd;
    assign irq     = s.irq;

    // ======================================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_status_pins; // [RL1]
        (paddr == `SGPS_OFF_DATA) && setup && (s.index == `SGPS_IDX_STATUS)
        |=> prdata[7:0] == $past(stat_vec);
    endproperty
    a_status_pins: assert property (p_status_pins) else $error("status word wrong");

    property p_dir_write; // [RL2]
        wr_data && wr_ok && (s.index == `SGPS_IDX_DIR) && !suspend
        |=> gp_oe == $past(pwdata[7:2]);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction not applied");

    property p_pol_level; // [RL3]
        !s.sens[0] && s.pol[0] |-> cell_st[0] == pin_s[0];
    endproperty
    a_pol_level: assert property (p_pol_level) else $error("active high level wrong");

    property p_level_follow; // [RL4]
        !s.sens[2] && !s.pol[2] |-> cell_st[2] == !pin_s[2];
    endproperty
    a_level_follow: assert property (p_level_follow) else $error("level mode not following");

    property p_edge_set; // [RL5]
        cell_rise[3] && s.sens[3] && !wr_data && !suspend |=> cell_st[3];
    endproperty
    a_edge_set: assert property (p_edge_set) else $error("edge flag not set");

    property p_read_clear; // [RL6]
        rd_status && s.sens[4] && s.prdata[4] && !cell_rise[4] |=> !cell_st[4];
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("edge flag not cleared");

    property p_ps1_stop; // [RL7]
        ps1_stop && !wr_data |=> motion == SGPS_IDLE ##0 s.ev_stat[`SGPS_EV_PS1];
    endproperty
    a_ps1_stop: assert property (p_ps1_stop) else $error("sensor one did not stop");

    property p_ps2_done; // [RL8]
        ps2_done && moving_fwd && !ps1_stop && !wr_data
        |=> motion == SGPS_IDLE && s.ps2_late && !s.ps2_run;
    endproperty
    a_ps2_done: assert property (p_ps2_done) else $error("sensor two delayed stop wrong");

    property p_rev_immune; // [RL9]
        (s.cmd == SGPS_REV) && !wr_data && !ps1_stop |=> motion == SGPS_REV;
    endproperty
    a_rev_immune: assert property (p_rev_immune) else $error("reverse stopped wrongly");

    property p_out_write; // [RL10]
        wr_data && wr_ok && (s.index == `SGPS_IDX_OUTV) && !suspend
        |=> gp_out == $past(pwdata[7:2]);
    endproperty
    a_out_write: assert property (p_out_write) else $error("output value not applied");

    property p_softrst_keep; // [RL11]
        wr_data && (s.index == `SGPS_IDX_CMD) && (pwdata[2:0] == 3'h4) && !suspend
        |=> $stable(s.dir) && $stable(s.outv) && $stable(s.sens);
    endproperty
    a_softrst_keep: assert property (p_softrst_keep) else $error("soft reset touched pins");

    property p_suspend_dflt; // [RL11]
        suspend |=> s.dir == `SGPS_RST_DIR && s.sens == `SGPS_RST_SENS;
    endproperty
    a_suspend_dflt: assert property (p_suspend_dflt) else $error("suspend kept settings");

    property p_reset_dflt; // [RL12] [RL13]
        !$past(rst_n) |-> gp_oe == 6'h38 && gp_out == 6'h18 && s.sens == 8'h1C && !s.pol[2];
    endproperty
    a_reset_dflt: assert property (p_reset_dflt) else $error("pin defaults wrong");

    property p_index_hold; // [RL14]
        access && pwrite && (paddr == `SGPS_OFF_INDEX) |=> s.index == $past(pwdata[6:0])
        ##1 (s.index == $past(s.index)) || $past(access && pwrite);
    endproperty
    a_index_hold: assert property (p_index_hold) else $error("index not held");

    property p_busy_locked; // [RL16]
        wr_data && (s.cmd == SGPS_SCAN) && (s.index == `SGPS_IDX_STOP) |=> $stable(s.stopcfg);
    endproperty
    a_busy_locked: assert property (p_busy_locked) else $error("write accepted while busy");

    property p_sync_delay; // [RL17]
        $past(rst_n, 2) |-> pin_s[0] == $past(sheet_sense1, 2);
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("synchroniser depth wrong");

endmodule : sgps_top

// [verification/sgps_pads.sv]
// Pad model of the far side: two sheet sensors and six general pins.
// Assumes the bench moves sensor and button levels through this instance.
`timescale 1ns/1ps

module sgps_pads (
    input  wire logic [5:0] gp_out,
    input  wire logic [5:0] gp_oe,
    output logic            sheet_sense1,
    output logic            sheet_sense2,
    output logic [5:0]      gp_in
);
    // =====================================================================
    // Outside levels; pull-ups keep idle pins high, which reads false
    logic       sen1 = 1'b1, sen2 = 1'b1;
    logic [5:0] btn  = 6'h3F;

    // A pad driven by the block reads back its own level
    assign sheet_sense1 = sen1;
    assign sheet_sense2 = sen2;
    assign gp_in        = (gp_oe & gp_out) | (~gp_oe & btn);
endmodule : sgps_pads

// [verification/sgps_top_tb_top.sv]
// Self-checking bench for the sensor and general pin status block.
// Assumes sgps_cfg.svh on the include path and an APB master at 10 MHz.
`timescale 1ns/1ps
`include "sgps_cfg.svh"

module sgps_top_tb_top;
    import sgps_pkg::*;
    // =====================================================================
    // Stimulus, bus and table rows (index, write, data, expected read)
    typedef struct packed {logic [6:0] i; logic w; logic [7:0] d; logic [7:0] e;} sgps_row_s;
    sgps_row_s rows [10] = '{'{7'h58,1'b0,8'h00,8'hE0}, '{7'h59,1'b0,8'h00,8'h00},
        '{7'h5A,1'b0,8'h00,8'h1C}, '{7'h5B,1'b0,8'h00,8'h60}, '{7'h50,1'b0,8'h00,8'h00},
        '{7'h51,1'b0,8'h00,8'h00}, '{7'h5B,1'b1,8'hFF,8'hFC}, '{7'h5B,1'b1,8'h60,8'h60},
        '{7'h50,1'b1,8'h03,8'h00}, '{7'h7F,1'b1,8'hFF,8'h00}};
    logic        ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        line_tick = 1'b0, suspend = 1'b0, pready, pslverr, irq, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [5:0]  gp_in, gp_out, gp_oe;
    logic        sheet_sense1, sheet_sense2;
    sgps_motion_e motion;
    int          errors = 0, checked = 0;

    // Free-running clock, 100 ns period
    always #50 ref_clk = ~ref_clk;

    sgps_top sgps_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sheet_sense1(sheet_sense1), .sheet_sense2(sheet_sense2),
        .gp_in(gp_in), .gp_out(gp_out), .gp_oe(gp_oe), .line_tick(line_tick),
        .suspend(suspend), .motion(motion), .irq(irq));
    sgps_pads sgps_pads_i (.gp_out(gp_out), .gp_oe(gp_oe), .sheet_sense1(sheet_sense1),
        .sheet_sense2(sheet_sense2), .gp_in(gp_in));

    // =====================================================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; held until pready is seen high, bounded wait
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge ref_clk);
            n++;
        end
        if (n == 20)
        begin
            errors++;
            finish_test();
        end
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge ref_clk);
    endtask : apb

    // Index first, then data: both steps every time keep the order plain
    task automatic wr(input logic [6:0] i, input logic [7:0] d);
        apb(1'b1, `SGPS_OFF_INDEX, {25'h0, i});
        apb(1'b1, `SGPS_OFF_DATA, {24'h0, d});
    endtask : wr

    task automatic rd(input logic [6:0] i);
        apb(1'b1, `SGPS_OFF_INDEX, {25'h0, i});
        apb(1'b0, `SGPS_OFF_DATA, 32'h0);
    endtask : rd

    task automatic tick();
        repeat (4) @(negedge ref_clk);
        @(posedge ref_clk) line_tick <= 1'b1;
        @(posedge ref_clk) line_tick <= 1'b0;
        repeat (2) @(negedge ref_clk);
    endtask : tick

    task automatic finish_test();
        if (errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test

    // =====================================================================
    // Main sequence: reset, table rows, then the awkward cases
    initial
    begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        chk({gp_oe, gp_out, motion, irq}, {6'h38, 6'h18, 3'h0, 1'b0});
        rd(7'h02);
        chk(rdat, 32'h0000_0080);
        foreach (rows[k])
        begin
            if (rows[k].w) // Rows never write 0-2
                wr(rows[k].i, rows[k].d);
            rd(rows[k].i);
            chk(rdat, {24'h0, rows[k].e});
        end
        // Falling edge on general pin one, then read clears the flag
        @(posedge ref_clk) sgps_pads_i.btn[0] <= 1'b0;
        rd(7'h02);
        chk(rdat[4:2], 3'b001);
        rd(7'h02);
        chk(rdat[4:2], 3'b000);
        @(posedge ref_clk) sgps_pads_i.btn[0] <= 1'b1;
        // Level mode follows the pin; polarity flips the reading
        wr(7'h5A, 8'h00);
        @(posedge ref_clk) sgps_pads_i.btn[1] <= 1'b0;
        repeat (2)
        begin
            rd(7'h02);
            chk(rdat[3], 1'b1);
        end
        wr(7'h59, 8'h08);
        rd(7'h02);
        chk(rdat[3], 1'b0);
        @(posedge ref_clk) sgps_pads_i.btn[1] <= 1'b1;
        // Pin one as output, outputs written; suspend restores defaults
        wr(7'h58, 8'hE4);
        wr(7'h5B, 8'h04);
        chk({gp_oe, gp_out}, {6'h39, 6'h01});
        @(posedge ref_clk) suspend <= 1'b1;
        @(posedge ref_clk) suspend <= 1'b0;
        rd(7'h58);
        chk({gp_oe, gp_out, rdat[7:0]}, {6'h38, 6'h18, 8'hE0});
        // Every motion command except idle, ending in soft reset
        for (int k = 1; k < 5; k++)
        begin
            wr(7'h07, k[7:0]);
            chk(motion, k);
        end
        wr(7'h50, 8'h03);
        wr(7'h51, 8'h02);
        rd(7'h50);
        chk({gp_oe, rdat[7:0]}, {6'h38, 8'h03});
        apb(1'b1, `SGPS_OFF_IEN, 32'h3);
        // Sensor one stops a scan and raises the interrupt
        wr(7'h07, 8'h03);
        @(posedge ref_clk) sgps_pads_i.sen1 <= 1'b0;
        repeat (6) @(negedge ref_clk);
        chk({motion, irq}, {3'h0, 1'b1});
        apb(1'b1, `SGPS_OFF_ICLR, 32'h7);
        chk(irq, 1'b0);
        @(posedge ref_clk) sgps_pads_i.sen1 <= 1'b1;
        // Sensor two leaves fast reverse alone, stops forward two lines on
        wr(7'h07, 8'h02);
        @(posedge ref_clk) sgps_pads_i.sen2 <= 1'b0;
        repeat (2) tick();
        chk(motion, 3'h2);
        @(posedge ref_clk) sgps_pads_i.sen2 <= 1'b1;
        rd(7'h02);
        wr(7'h07, 8'h01);
        @(posedge ref_clk) sgps_pads_i.sen2 <= 1'b0;
        tick();
        chk(motion, 3'h1);
        tick();
        rd(7'h02);
        chk({motion, rdat[1]}, {3'h0, 1'b1});
        // Unmapped offset answers with an error
        apb(1'b0, 12'h100, 32'h0);
        chk({err, rdat[30:0]}, 32'h80000000);
        finish_test();
    end
endmodule : sgps_top_tb_top
